//--- rtl/wdcc_config.v
// Serial command decoder and configuration registers for clock output,
// wake timer, duty-cycle receive and battery threshold.
// Assumes sclk, sdi, sel_n come from the host unsynchronised.
// Also assumes supply_below_thr comes from an analog comparator, untimed.
// Register contents are write-only; only status bit 10 is reported back.
// Wake and offset times are counted in ref_clk cycles set by parameters.
`timescale 1ns/1ns
`include "wdcc_defines.vh"

module wdcc_config #(
  parameter [19:0] WAKE_UNIT_CYC = `WDCC_WAKE_UNIT_CYC,
  parameter [19:0] WAKE_OFS_CYC  = `WDCC_WAKE_OFS_CYC
) (
  input  wire        ref_clk,
  input  wire        resetn,
  // Host serial port
  input  wire        sclk,
  input  wire        sdi,
  input  wire        sel_n,
  // Analog comparator
  input  wire        supply_below_thr,
  // Control and status outputs
  output reg         clk_out,
  output reg         crystal_osc_run,
  output reg         rx_chain_active,
  output reg         battery_detect_run,
  output reg  [3:0]  battery_threshold_code,
  output reg  [2:0]  clk_out_freq_sel,
  output reg  [15:0] status_word,
  output reg         wake_event
);

  // Wake timer phases: idle, fixed offset, interval units, receive window.
  // Binary codes; the receive window is used in duty mode only.
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_OFS  = 2'd1;
  localparam [1:0] ST_CNT  = 2'd2;
  localparam [1:0] ST_RXW  = 2'd3;

  // Units to count: value times two to the exponent
  // Exponents up to 30 still fit the 38-bit result
  function [37:0] scaled;
    input [7:0] val;
    input [4:0] expo;
    begin
      scaled = {30'h0000_0000, val} << expo;
    end
  endfunction

  // Clock output period in ref_clk cycles
  function [7:0] clk_div;
    input [2:0] sel;
    begin
      case (sel)
        3'h7:    clk_div = 8'd25;
        3'h6:    clk_div = 8'd50;
        3'h5:    clk_div = 8'd75;
        3'h4:    clk_div = 8'd100;
        3'h3:    clk_div = 8'd125;
        3'h2:    clk_div = 8'd150;
        3'h1:    clk_div = 8'd200;
        default: clk_div = 8'd250;
      endcase
    end
  endfunction

  // Upper-byte command code match
  function pfx8_hit;
    input [15:0] w;
    input [7:0]  pfx;
    begin
      pfx8_hit = (w[15:8] == pfx);
    end
  endfunction

  // Synchroniser stages
  reg [2:0]  sclk_sync_q;
  reg [1:0]  sdi_sync_q;
  reg [1:0]  sel_sync_q;
  reg [1:0]  batt_sync_q;

  // Serial receive
  reg [15:0] shift_q;
  reg [4:0]  bit_cnt_q;

  // Stored configuration words
  reg [15:0] power_q;
  reg [15:0] wake_q;
  reg [15:0] duty_q;
  reg [15:0] batt_q;

  // Wake timer
  reg [1:0]  state_q;
  reg [19:0] cyc_q;
  reg [37:0] unit_q;
  reg [37:0] target_q;
  reg        wake_on_dly_q;

  // Clock divider
  reg [7:0]  div_q;

  // Decode of the synchronised serial port and the stored fields
  wire        sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
  wire [15:0] word      = {shift_q[14:0], sdi_sync_q[1]};
  wire        last_bit  = sclk_rise & ~sel_sync_q[1] & (bit_cnt_q == `WDCC_CMD_BITS - 5'd1);
  wire        wake_on   = power_q[`WDCC_BIT_WAKE_ON];
  wire        duty_on   = duty_q[`WDCC_BIT_DUTY_ON];
  wire        clk_en    = ~power_q[`WDCC_BIT_CLKOUT_DIS];
  wire        unit_tick = (cyc_q == WAKE_UNIT_CYC - 20'd1);
  wire [37:0] wake_len  = scaled(wake_q[7:0], wake_q[12:8]); // RQ7
  wire [37:0] rxw_len   = scaled({duty_q[7:1], 1'b1}, wake_q[12:8]); // RQ13
  wire [7:0]  div_max   = clk_div(batt_q[7:5]) - 8'd1;

  // Synchronisers; only the second stage feeds logic.
  // Serial clock keeps a third stage so its rising edge can be found.
  always @(posedge ref_clk) begin
    if (!resetn) begin
      sclk_sync_q <= 3'h0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], sclk};
    end
  end

  always @(posedge ref_clk) begin
    if (!resetn) begin
      sdi_sync_q <= 2'h0;
    end else begin
      sdi_sync_q <= {sdi_sync_q[0], sdi};
    end
  end

  // Select resets to idle high so reset release starts no word
  always @(posedge ref_clk) begin
    if (!resetn) begin
      sel_sync_q <= 2'h3;
    end else begin
      sel_sync_q <= {sel_sync_q[0], sel_n};
    end
  end

  // Comparator output is analog-side, so it is treated as asynchronous
  always @(posedge ref_clk) begin
    if (!resetn) begin
      batt_sync_q <= 2'h0;
    end else begin
      batt_sync_q <= {batt_sync_q[0], supply_below_thr};
    end
  end

  // Serial shift; bits past sixteen are dropped until select goes high
  always @(posedge ref_clk) begin
    if (!resetn) begin
      shift_q <= 16'h0000; // RQ21
    end else if (!sel_sync_q[1] && sclk_rise && bit_cnt_q != `WDCC_CMD_BITS) begin
      shift_q <= word;
    end
  end

  // Counter clears on deselect, so a cut word never reaches sixteen
  always @(posedge ref_clk) begin
    if (!resetn) begin
      bit_cnt_q <= 5'd0; // RQ21
    end else if (sel_sync_q[1]) begin
      bit_cnt_q <= 5'd0;
    end else if (sclk_rise && bit_cnt_q != `WDCC_CMD_BITS) begin
      bit_cnt_q <= bit_cnt_q + 5'd1;
    end
  end

  // Register writes, committed on the sixteenth bit only.
  // Each register has its own process so a word can only touch its target.
  always @(posedge ref_clk) begin
    if (!resetn) begin
      power_q <= `WDCC_RST_POWER; // RQ1
    end else if (last_bit && pfx8_hit(word, `WDCC_PFX_POWER)) begin // RQ22
      power_q <= word; // RQ2 RQ20 RQ19
    end
  end

  // Wake register decodes a three-bit code, unlike the others
  always @(posedge ref_clk) begin
    if (!resetn) begin
      wake_q <= `WDCC_RST_WAKE;
    end else if (last_bit && word[15:13] == `WDCC_PFX_WAKE) begin // RQ22
      wake_q <= word; // RQ4 RQ6
    end
  end

  always @(posedge ref_clk) begin
    if (!resetn) begin
      duty_q <= `WDCC_RST_DUTY;
    end else if (last_bit && pfx8_hit(word, `WDCC_PFX_DUTY)) begin // RQ22
      duty_q <= word; // RQ9 RQ10
    end
  end

  // Reserved bit 4 is stored as written; nothing reads it
  always @(posedge ref_clk) begin
    if (!resetn) begin
      batt_q <= `WDCC_RST_BATT;
    end else if (last_bit && pfx8_hit(word, `WDCC_PFX_BATT)) begin // RQ22
      batt_q <= word; // RQ14 RQ17
    end
  end

  // Wake timer: offset phase, then interval units, then optional receive window.
  // One-shot unless duty mode is on; host re-arms by toggling the enable.
  always @(posedge ref_clk) begin
    if (!resetn) begin
      state_q       <= ST_IDLE;
      cyc_q         <= 20'd0;
      unit_q        <= 38'd0;
      target_q      <= 38'd0;
      wake_on_dly_q <= 1'b0;
      wake_event    <= 1'b0;
    end else begin
      wake_on_dly_q <= wake_on;
      wake_event    <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          cyc_q <= 20'd0;
          // Arms only on the enable's rising edge
          if (wake_on && !wake_on_dly_q) begin
            state_q <= ST_OFS; // RQ8
          end
        end
        ST_OFS: begin
          // Fixed offset first, then the scaled interval
          if (cyc_q == WAKE_OFS_CYC - 20'd1) begin
            cyc_q    <= 20'd0;
            unit_q   <= 38'd0;
            target_q <= wake_len;
            state_q  <= ST_CNT;
          end else begin
            cyc_q <= cyc_q + 20'd1;
          end
        end
        ST_CNT: begin
          // Target latched at the start so a rewrite mid-count has no effect
          if (unit_q == target_q) begin
            wake_event <= 1'b1; // RQ7
            cyc_q      <= 20'd0;
            unit_q     <= 38'd0;
            target_q   <= rxw_len;
            state_q    <= duty_on ? ST_RXW : ST_IDLE; // RQ12
          end else if (unit_tick) begin
            cyc_q  <= 20'd0;
            unit_q <= unit_q + 38'd1;
          end else begin
            cyc_q <= cyc_q + 20'd1;
          end
        end
        ST_RXW: begin
          // Leave on the last unit's tick so the window is exactly its units long
          if (!duty_on || (unit_tick && unit_q == target_q - 38'd1)) begin
            cyc_q   <= 20'd0;
            state_q <= duty_on ? ST_OFS : ST_IDLE; // RQ12
          end else if (unit_tick) begin
            cyc_q  <= 20'd0;
            unit_q <= unit_q + 38'd1;
          end else begin
            cyc_q <= cyc_q + 20'd1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      // Disabling the timer wins over any phase
      if (!wake_on) begin
        state_q <= ST_IDLE; // RQ20
      end
    end
  end

  // Clock output divider; odd periods give a one-cycle duty skew.
  // Counter parks at zero while off, so re-enabling starts a full high phase.
  always @(posedge ref_clk) begin
    if (!resetn) begin
      div_q <= 8'd0;
    end else if (!clk_en || div_q >= div_max) begin
      div_q <= 8'd0;
    end else begin
      div_q <= div_q + 8'd1;
    end
  end

  always @(posedge ref_clk) begin
    if (!resetn) begin
      clk_out <= 1'b0;
    end else begin
      clk_out <= clk_en & (div_q <= {1'b0, div_max[7:1]}); // RQ15 RQ2
    end
  end

  // Registered control and status outputs, one process each
  always @(posedge ref_clk) begin
    if (!resetn) begin
      crystal_osc_run <= 1'b1; // RQ1
    end else begin
      crystal_osc_run <= power_q[`WDCC_BIT_OSC_ON] | clk_en; // RQ3
    end
  end

  // Receive window only counts while duty mode is still on
  always @(posedge ref_clk) begin
    if (!resetn) begin
      rx_chain_active <= 1'b0;
    end else begin
      rx_chain_active <= power_q[`WDCC_BIT_RX_ON] | (duty_on & (state_q == ST_RXW)); // RQ12
    end
  end

  always @(posedge ref_clk) begin
    if (!resetn) begin
      battery_detect_run <= 1'b0;
    end else begin
      battery_detect_run <= power_q[`WDCC_BIT_BATT_ON]; // RQ19
    end
  end

  always @(posedge ref_clk) begin
    if (!resetn) begin
      battery_threshold_code <= 4'h0;
    end else begin
      battery_threshold_code <= batt_q[3:0]; // RQ17
    end
  end

  always @(posedge ref_clk) begin
    if (!resetn) begin
      clk_out_freq_sel <= 3'h0;
    end else begin
      clk_out_freq_sel <= batt_q[7:5]; // RQ15
    end
  end

  // Only the low-battery bit is live; the rest of the status word reads zero
  always @(posedge ref_clk) begin
    if (!resetn) begin
      status_word <= 16'h0000;
    end else begin
      status_word                     <= 16'h0000;
      status_word[`WDCC_BIT_BATT_LOW] <= power_q[`WDCC_BIT_BATT_ON] & batt_sync_q[1]; // RQ18 RQ19
    end
  end

endmodule // wdcc_config

//--- shared/wdcc_defines.vh
// Constants for the wake, duty-cycle and clock-output configuration block.
// Assumes a 250 MHz ref_clk and 16-bit serial command words, MSB first.
// Overview of operation
// (RQ1) After reset the clock output pin is running by default.
// (RQ2) Power bit 0 is active low: 1 stops clock output, 0 runs it.
// (RQ3) While clock output runs, the crystal oscillator stays on regardless of its enable.
// (RQ4) Words with top bits 111b write the wake interval register.
// (RQ5) Host keeps the wake exponent in bits 12..8 within 0 to 29.
// (RQ6) Wake interval bits 7..0 hold an eight-bit multiplier, 0 to 255.
// (RQ7) Wake timer expires after 1.03 ms times multiplier times two-to-exponent, plus 0.5 ms.
// (RQ8) Host clears then sets the wake timer enable to re-arm each interval.
// (RQ9) Upper byte 11001000b writes the duty-cycle register.
// (RQ10) Duty register: seven-bit on-time multiplier in 7..1, mode enable in bit 0.
// (RQ11) Host keeps receiver chain off and wake timer on before duty mode.
// (RQ12) In duty mode each expiry opens a receive window, then sleeps again, repeating.
// (RQ13) Receive on-time ratio is twice duty multiplier plus one over wake multiplier.
// (RQ14) Upper byte 11000000b writes the battery threshold and clock frequency register.
// (RQ15) Bits 7..5 select clock output from 10 MHz down to 1 MHz.
// (RQ16) Host writes zero into reserved bit 4 of the battery/clock register.
// (RQ17) Four-bit battery code sets threshold at 2.25 V plus 0.1 V per step.
// (RQ18) Low battery flag is status bit 10, set 50 mV below threshold.
// (RQ19) Low battery detection runs only while the detector enable bit is set.
// (RQ20) Power bit 1 enables the wake timer circuit; 0 disables it.
// (RQ21) While in reset, serial command words are ignored.
// (RQ22) Only the addressed register updates, and only after all sixteen bits.
`ifndef WDCC_DEFINES_VH
`define WDCC_DEFINES_VH

`define WDCC_PFX_POWER      8'h82
`define WDCC_PFX_WAKE       3'h7
`define WDCC_PFX_DUTY       8'hc8
`define WDCC_PFX_BATT       8'hc0

`define WDCC_RST_POWER      16'h8208
`define WDCC_RST_WAKE       16'he196
`define WDCC_RST_DUTY       16'hc80e
`define WDCC_RST_BATT       16'hc000

`define WDCC_BIT_CLKOUT_DIS 0
`define WDCC_BIT_WAKE_ON    1
`define WDCC_BIT_BATT_ON    2
`define WDCC_BIT_OSC_ON     3
`define WDCC_BIT_RX_ON      7
`define WDCC_BIT_DUTY_ON    0
`define WDCC_BIT_BATT_LOW   10

`define WDCC_CLK_NS         4
`define WDCC_WAKE_UNIT_NS   1030000
`define WDCC_WAKE_OFS_NS    500000
`define WDCC_WAKE_UNIT_CYC  ((`WDCC_WAKE_UNIT_NS + `WDCC_CLK_NS - 1) / `WDCC_CLK_NS)
`define WDCC_WAKE_OFS_CYC   ((`WDCC_WAKE_OFS_NS + `WDCC_CLK_NS - 1) / `WDCC_CLK_NS)

`define WDCC_CMD_BITS       5'd16

`endif

//--- test/wdcc_config_props.sv
// Port-level assertions for the wake, duty and clock-output config block.
// Bound from the bench top; a single clock domain.
`timescale 1ns/1ns
module wdcc_config_props (
  input wire        ref_clk,
  input wire        resetn,
  input wire        sel_n,
  input wire        supply_below_thr,
  input wire        clk_out,
  input wire        crystal_osc_run,
  input wire        rx_chain_active,
  input wire        battery_detect_run,
  input wire [3:0]  battery_threshold_code,
  input wire [2:0]  clk_out_freq_sel,
  input wire [15:0] status_word,
  input wire        wake_event
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_osc_kept: assert property ($rose(clk_out) |-> crystal_osc_run) else $error("osc off");
  a_flag_set: assert property ((supply_below_thr && battery_detect_run) [*6] |-> status_word == 16'h0400) else $error("flag");
  a_flag_clr: assert property ((!supply_below_thr) [*6] |-> !status_word[10]) else $error("flag stuck");
  a_detect_off: assert property ((!battery_detect_run) [*2] |-> !status_word[10]) else $error("detect off");
  a_wake_pulse: assert property (wake_event |=> !wake_event) else $error("wake pulse");
  a_rx_window: assert property ($rose(rx_chain_active) |-> ##[1:1000] !rx_chain_active) else $error("rx window");
  a_cfg_held: assert property (sel_n [*8] |-> $stable({clk_out_freq_sel, battery_threshold_code})) else $error("cfg");
  a_clk_min_hi: assert property ($rose(clk_out) |-> (clk_out || !crystal_osc_run) [*8]) else $error("clk short");
endmodule // wdcc_config_props

//--- test/wdcc_host_model.sv
// Host side of the serial command port: words MSB first.
// Serial clock of 64 ns made from ref_clk; it stands low between words.
`timescale 1ns/1ns
module wdcc_host_model (
  input wire  ref_clk,
  output reg  sclk,
  output reg  sdi,
  output reg  sel_n
);
  integer i;
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    sel_n = 1'b1;
  end
  // Sends the top n bits; fewer than 16 gives a cut word
  task send(input [15:0] w, input integer n);
    begin
      @(posedge ref_clk) sel_n <= 1'b0;
      for (i = 15; i > 15 - n; i = i - 1) begin
        sdi <= w[i];
        repeat (8) @(posedge ref_clk);
        sclk <= 1'b1;
        repeat (8) @(posedge ref_clk);
        sclk <= 1'b0;
      end
      repeat (4) @(posedge ref_clk);
      sel_n <= 1'b1;
      sdi <= ~sdi;
      repeat (4) @(posedge ref_clk);
    end
  endtask
endmodule // wdcc_host_model

//--- test/tb_wake_duty_clkout_config.sv
// Self-checking bench for the config block with a behavioural host.
// Wake units shortened by parameter so timer runs stay short.
`timescale 1ns/1ns
module tb_wake_duty_clkout_config;
  reg         ref_clk = 1'b0;
  reg         resetn = 1'b0;
  reg         supply_below_thr = 1'b0;
  wire        sclk, sdi, sel_n, clk_out, crystal_osc_run, rx_chain_active, battery_detect_run, wake_event;
  wire [3:0]  battery_threshold_code;
  wire [2:0]  clk_out_freq_sel;
  wire [15:0] status_word;
  integer     bad_count = 0;
  integer     compares = 0;
  integer     i, n, t0;
  // Word beside its clock period in ref_clk cycles
  reg [23:0]  rows [0:7] = '{24'hc0ef19, 24'hc0c532, 24'hc0a34b, 24'hc08964,
                             24'hc0617d, 24'hc04c96, 24'hc027c8, 24'hc000fa};
  reg [15:0]  wk [0:3] = '{16'he000, 16'he002, 16'he101, 16'he0ff};
  reg [15:0]  wd [0:3] = '{16'd0, 16'd8, 16'd8, 16'd1020};

  always #2 ref_clk = ~ref_clk;

  wdcc_config #(.WAKE_UNIT_CYC(20'd4), .WAKE_OFS_CYC(20'd40)) uut (
    .ref_clk(ref_clk), .resetn(resetn), .sclk(sclk), .sdi(sdi), .sel_n(sel_n),
    .supply_below_thr(supply_below_thr), .clk_out(clk_out), .crystal_osc_run(crystal_osc_run),
    .rx_chain_active(rx_chain_active), .battery_detect_run(battery_detect_run),
    .battery_threshold_code(battery_threshold_code), .clk_out_freq_sel(clk_out_freq_sel),
    .status_word(status_word), .wake_event(wake_event));
  wdcc_host_model host (.ref_clk(ref_clk), .sclk(sclk), .sdi(sdi), .sel_n(sel_n));

  task check(input string what, input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task report_and_stop;
    begin
      if (bad_count == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  // Cycles until the chosen output shows lvl
  task wait_for(input integer s, input lvl, output integer c);
    begin
      c = 0;
      while (((s == 0) ? wake_event : (s == 1) ? rx_chain_active : clk_out) !== lvl) begin
        @(posedge ref_clk);
        c = c + 1;
        if (c > 3000) begin
          bad_count = bad_count + 1;
          report_and_stop;
        end
      end
    end
  endtask

  // Skips the phase in progress, then times one full period
  task period(output integer p);
    integer h;
    begin
      wait_for(2, 0, h);
      wait_for(2, 1, h);
      wait_for(2, 0, h);
      wait_for(2, 1, p);
      p = p + h;
    end
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    check("reset pins", {14'd0, clk_out, crystal_osc_run}, 16'h0001);
    resetn <= 1'b1;
    period(n);
    check("reset period", n[15:0], 16'd250);
    for (i = 0; i < 8; i = i + 1) begin
      host.send(rows[i][23:8], 16);
      check("bcfg", {8'd0, clk_out_freq_sel, 1'b0, battery_threshold_code}, {8'd0, rows[i][15:8]});
      period(n);
      check("period", n[15:0], {8'd0, rows[i][7:0]});
    end
    host.send(16'h8201, 16);
    n = 0;
    repeat (260) begin
      @(posedge ref_clk);
      n = n | clk_out | crystal_osc_run;
    end
    check("clk off", n[15:0], 16'h0000);
    host.send(16'h8200, 16);
    period(n);
    check("clk on", {n[14:0], crystal_osc_run}, 16'd501);
    supply_below_thr <= 1'b1;
    host.send(16'h8204, 16);
    check("flag on", status_word | battery_detect_run, 16'h0401);
    host.send(16'h8200, 16);
    check("flag off", status_word | battery_detect_run, 16'h0000);
    supply_below_thr <= 1'b0;
    // Exponents stay in range; timer re-armed by clearing then setting its enable
    for (i = 0; i < 4; i = i + 1) begin
      host.send(wk[i], 16);
      host.send(16'h8200, 16);
      host.send(16'h8202, 16);
      wait_for(0, 1, n);
      if (i == 0)
        t0 = n;
      n = n - t0;
      check("wake delay", n[15:0], wd[i]);
    end
    host.send(16'he004, 16);
    host.send(16'hc803, 16);
    host.send(16'h8200, 16);
    host.send(16'h8202, 16);
    wait_for(1, 1, n);
    wait_for(1, 0, n);
    check("rx window", n[15:0], 16'd12);
    wait_for(1, 1, n);
    check("rx again", {15'd0, n > 40}, 16'h0001);
    host.send(16'hc802, 16);
    host.send(16'h8200, 16);
    check("duty off", {15'd0, rx_chain_active}, 16'h0000);
    resetn <= 1'b0;
    host.send(16'hc0e5, 16);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("in reset", {13'd0, clk_out_freq_sel}, 16'h0000);
    host.send(16'hc0e5, 8);
    host.send(16'hc4e5, 16);
    check("no write", {12'd0, battery_threshold_code}, 16'h0000);
    host.send(16'hc0e5, 16);
    check("full word", {8'd0, clk_out_freq_sel, 1'b0, battery_threshold_code}, 16'h00e5);
    report_and_stop;
  end
endmodule // tb_wake_duty_clkout_config

bind wdcc_config wdcc_config_props chk (
  .ref_clk(ref_clk), .resetn(resetn), .sel_n(sel_n), .supply_below_thr(supply_below_thr),
  .clk_out(clk_out), .crystal_osc_run(crystal_osc_run), .rx_chain_active(rx_chain_active),
  .battery_detect_run(battery_detect_run), .battery_threshold_code(battery_threshold_code),
  .clk_out_freq_sel(clk_out_freq_sel), .status_word(status_word), .wake_event(wake_event));
